//--- testbench/ipm_core_model.sv
`timescale 1ns/100ps
// Core stand-in: it acks a standing request after a set delay and passes returns on.
module ipm_core_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_req,
  input  wire logic [2:0] i_lat,
  input  wire logic       i_ret_cmd,
  output logic            o_ack,
  output logic            o_ret
);
  logic       seen = 1'b0;
  logic       rq   = 1'b0;
  logic [2:0] cnt  = 3'h0;

  initial begin
    o_ack = 1'b0;
    o_ret = 1'b0;
  end

  // Sample at the rising edge so falling-edge bench updates never race the model.
  always @(posedge i_clk) begin
    seen <= i_req;
    rq   <= i_ret_cmd;
  end

  // Ack is a one-cycle pulse; a request that drops early restarts the delay.
  always @(negedge i_clk) begin
    o_ret <= rq && !i_rst;
    if (i_rst || o_ack || !seen) begin
      o_ack <= 1'b0;
      cnt   <= 3'h0;
    end else if (cnt >= i_lat) begin
      o_ack <= 1'b1;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end
endmodule : ipm_core_model

//--- testbench/test_interrupt_priority_power_modes.sv
`timescale 1ns/100ps
module test_interrupt_priority_power_modes
  import ipm_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  flg = 10'h0;
  logic [9:0]  en  = 10'h3ff;
  logic [1:0]  pr [10] = '{default: 2'h0};
  logic [1:0]  pk  = 2'h0;
  logic        ge  = 1'b1;
  logic        lv0 = 1'b0;
  logic        lv1 = 1'b0;
  logic        pw  = 1'b0;
  logic        ret_cmd = 1'b0;
  logic [7:0]  power_control_register_d  = 8'h00;
  logic [2:0]  lat = 3'h2;
  logic [15:0] vt [10] = '{IPM_VEC_EXT0, IPM_VEC_BO, IPM_VEC_T0, IPM_VEC_EXT1, IPM_VEC_T1,
                           IPM_VEC_PCA, IPM_VEC_EXT2, IPM_VEC_EXT3, IPM_VEC_SER, IPM_VEC_T2};
  logic [19:0] exp_q [$];
  logic        irq, bor, idle_request_bit, pdb, hlt, stp, ale, pse_n, ack, sret;
  logic [15:0] vec;
  logic [3:0]  src;
  int          miscompares = 0;
  int          n_tests = 0;
  int          n_ack = 0;

  always #5 clk = ~clk;

  // Shared sources pick one of their flags through pk, so every flag gets used.
  ipm_interrupt_power i_dut (
    .i_clk_sys(clk), .i_rst(rst), .i_ext0_request_flag(flg[0]), .i_ext1_request_flag(flg[3]),
    .i_ext2_request_flag(flg[6]), .i_ext3_request_flag(flg[7]), .i_ext0_level_mode(lv0),
    .i_ext1_level_mode(lv1), .i_brownout(flg[1]), .i_timer0_overflow_flag(flg[2]),
    .i_timer1_overflow_flag(flg[4]), .i_timer2_overflow_flag(flg[9] && !pk[0]),
    .i_timer2_external_flag(flg[9] && pk[0]), .i_counter_array_overflow_flag(flg[5] && !pk[0]),
    .i_counter_module_match_flag(flg[5] && pk[0]), .i_spi_done_flag(flg[8] && pk[1]),
    .i_serial_transmit_flag(flg[8] && pk == 2'h0), .i_serial_receive_flag(flg[8] && pk == 2'h1),
    .i_global_enable(ge), .i_ext0_enable(en[0]), .i_brownout_irq_enable(en[1]),
    .i_timer0_irq_enable(en[2]), .i_ext1_enable(en[3]), .i_timer1_irq_enable(en[4]),
    .i_counter_array_irq_enable(en[5]), .i_ext2_enable(en[6]), .i_ext3_enable(en[7]),
    .i_serial_irq_enable(en[8]), .i_timer2_irq_enable(en[9]), .i_ext0_priority_bits(pr[0]),
    .i_brownout_priority_bits(pr[1]), .i_timer0_priority_bits(pr[2]),
    .i_ext1_priority_bits(pr[3]), .i_timer1_priority_bits(pr[4]),
    .i_counter_array_priority_bits(pr[5]), .i_ext2_priority_bits(pr[6]),
    .i_ext3_priority_bits(pr[7]), .i_serial_priority_bits(pr[8]),
    .i_timer2_priority_bits(pr[9]), .i_power_control_register_write(pw), .i_power_control_register_wdata(power_control_register_d),
    .i_vector_ack(ack), .i_service_return(sret), .o_irq_request(irq), .o_vector_address(vec),
    .o_irq_source(src), .o_brownout_reset(bor), .o_idle_request_bit(idle_request_bit),
    .o_powerdown_request_bit(pdb), .o_cpu_halt(hlt), .o_clock_stop(stp), .o_ale(ale),
    .o_program_store_enable_n(pse_n));

  ipm_core_model i_core (.i_clk(clk), .i_rst(rst), .i_req(irq), .i_lat(lat),
    .i_ret_cmd(ret_cmd), .o_ack(ack), .o_ret(sret));

  task automatic chk(input logic [19:0] got, input logic [19:0] want);
    n_tests++;
    if (got !== want) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize

  // Each taken request retires the oldest noted source and vector.
  always @(posedge clk) begin
    if (!rst && irq === 1'b1 && ack === 1'b1) begin
      n_ack++;
      if (exp_q.size() == 0) chk(20'hfffff, {src, vec});
      else chk({src, vec}, exp_q.pop_front());
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic power_control_register(input logic [7:0] v);
    power_control_register_d = v;
    pw = 1'b1;
    cyc(1);
    pw = 1'b0;
    cyc(2);
  endtask : power_control_register

  // Waits, bounded, for the core to take a request, then the source drops its flag.
  task automatic take(input int idx);
    int base;
    base = n_ack;
    for (int k = 0; k < 60 && n_ack == base; k++) cyc(1);
    chk(20'(n_ack - base), 20'h1);
    flg[idx] = 1'b0;
  endtask : take

  task automatic ret();
    ret_cmd = 1'b1;
    cyc(1);
    ret_cmd = 1'b0;
    cyc(3);
  endtask : ret

  // Highest level wins; on a tie the earlier polling slot wins.
  function automatic int win(input logic [9:0] m);
    int w;
    w = -1;
    for (int i = 0; i < 10; i++) if (m[i] && (w < 0 || pr[i] > pr[w])) w = i;
    return w;
  endfunction : win

  initial begin
    logic [9:0] m;
    int         w;
    void'($urandom(53378));
    cyc(8);
    rst = 1'b0;
    cyc(1);
    chk({12'h0, idle_request_bit, pdb, hlt, stp, ale, pse_n, irq, bor}, 20'h0c);
    // All ten sources at once, served one by one: flat levels, then random levels.
    for (int r = 0; r < 3; r++) begin
      foreach (pr[i]) pr[i] = (r == 0) ? 2'h0 : 2'($urandom % 4);
      pk = 2'(r);
      lat = 3'(2 + $urandom % 3);
      m = 10'h3ff;
      flg = m;
      while (m != 10'h0) begin
        w = win(m);
        exp_q.push_back({4'(w), vt[w]});
        take(w);
        m[w] = 1'b0;
        ret();
      end
    end
    // Equal level or cleared global enable must not preempt a running routine.
    pr = '{default: 2'h0};
    pr[9] = 2'h1;
    flg[9] = 1'b1;
    exp_q.push_back({4'd9, vt[9]});
    take(9);
    flg[0] = 1'b1;
    pr[0] = 2'h1;
    cyc(4);
    chk({19'h0, irq}, 20'h0);
    pr[0] = 2'h2;
    ge = 1'b0;
    cyc(4);
    chk({19'h0, irq}, 20'h0);
    exp_q.push_back({4'd0, vt[0]});
    ge = 1'b1;
    take(0);
    ret();
    ret();
    // Idle halts the core with strobes high; any enabled interrupt ends it.
    pr = '{default: 2'h0};
    power_control_register(IPM_POWER_CONTROL_REGISTER_IDLE_VAL);
    chk({14'h0, idle_request_bit, hlt, ale, pse_n, stp, pdb}, 20'h3c);
    flg[2] = 1'b1;
    exp_q.push_back({4'd2, vt[2]});
    take(2);
    cyc(2);
    chk({18'h0, idle_request_bit, hlt}, 20'h0);
    ret();
    // Timer, edge-mode ext1, ext2 and ext3 must leave power-down untouched.
    power_control_register(IPM_POWER_CONTROL_REGISTER_PD_VAL);
    chk({16'h0, pdb, stp, ale, pse_n}, 20'hc);
    flg = 10'h0cc;
    cyc(8);
    chk({17'h0, irq, pdb, stp}, 20'h3);
    lv0 = 1'b1;
    exp_q.push_back({4'd0, vt[0]});
    w = n_ack;
    flg[0] = 1'b1;
    cyc(1024);
    flg = 10'h0;
    cyc(2);
    chk(20'(n_ack - w), 20'h1);
    chk({18'h0, pdb, stp}, 20'h0);
    ret();
    // Reset in either low-power mode returns to the running state.
    for (int k = 0; k < 2; k++) begin
      power_control_register(k == 0 ? IPM_POWER_CONTROL_REGISTER_IDLE_VAL : IPM_POWER_CONTROL_REGISTER_PD_VAL);
      rst = 1'b1;
      cyc(1);
      rst = 1'b0;
      cyc(1);
      chk({14'h0, idle_request_bit, pdb, hlt, stp, ale, pse_n}, 20'h3);
    end
    // Brown-out with its interrupt disabled resets instead of vectoring.
    en[1] = 1'b0;
    flg[1] = 1'b1;
    cyc(2);
    chk({18'h0, bor, irq}, 20'h2);
    flg[1] = 1'b0;
    chk(20'(exp_q.size()), 20'h0);
    summarize();
  end

  // The whole run is near 1300 cycles; this limit leaves a wide margin.
  initial begin
    #200000;
    miscompares++;
    summarize();
  end
endmodule : test_interrupt_priority_power_modes

//--- verilog/ipm_interrupt_power.sv
`timescale 1ns/100ps
// Behaviour
// - Four priority levels; higher level pending request is serviced first.
// - Serial transmit, receive and SPI done share one source at 0023H.
// - Each source presents its fixed vector address.
// - Within one level, fixed polling order ext0 first, timer2 last.
// - Writing 01H to power control sets idle bit; core halts, rest runs.
// - Register and RAM contents stay unchanged while idle.
// - Taking an enabled interrupt while idle clears the idle bit.
// - After return, code resumes after the instruction that entered low power.
// - Address latch strobe and program store enable held high while idle.
// - Hardware reset ends idle or power-down like a power-on reset.
// - Writing 02H to power control sets power-down bit, enters power-down.
// - Power-down stops the clock; only level external requests register.
// - SRAM and register contents retained through power-down.
// - Only enabled level ext0 or ext1 wakes power-down, or reset.
// - Taking the wake-up interrupt clears the power-down bit.
// - Wake pin returning high starts the service routine's first instruction; here the clock restarts and the wake is taken while the pin is still low.
// - Address latch strobe and program store enable held low in power-down.
// - Brown-out enable is bit 3 at E8H; clear means reset to 0000H.
module ipm_interrupt_power
  import ipm_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_ext0_request_flag,
  input  wire logic        i_ext1_request_flag,
  input  wire logic        i_ext2_request_flag,
  input  wire logic        i_ext3_request_flag,
  input  wire logic        i_ext0_level_mode,
  input  wire logic        i_ext1_level_mode,
  input  wire logic        i_brownout,
  input  wire logic        i_timer0_overflow_flag,
  input  wire logic        i_timer1_overflow_flag,
  input  wire logic        i_timer2_overflow_flag,
  input  wire logic        i_timer2_external_flag,
  input  wire logic        i_counter_array_overflow_flag,
  input  wire logic        i_counter_module_match_flag,
  input  wire logic        i_serial_transmit_flag,
  input  wire logic        i_serial_receive_flag,
  input  wire logic        i_spi_done_flag,
  input  wire logic        i_global_enable,
  input  wire logic        i_ext0_enable,
  input  wire logic        i_brownout_irq_enable,
  input  wire logic        i_timer0_irq_enable,
  input  wire logic        i_ext1_enable,
  input  wire logic        i_timer1_irq_enable,
  input  wire logic        i_counter_array_irq_enable,
  input  wire logic        i_ext2_enable,
  input  wire logic        i_ext3_enable,
  input  wire logic        i_serial_irq_enable,
  input  wire logic        i_timer2_irq_enable,
  input  wire logic [1:0]  i_ext0_priority_bits,
  input  wire logic [1:0]  i_brownout_priority_bits,
  input  wire logic [1:0]  i_timer0_priority_bits,
  input  wire logic [1:0]  i_ext1_priority_bits,
  input  wire logic [1:0]  i_timer1_priority_bits,
  input  wire logic [1:0]  i_counter_array_priority_bits,
  input  wire logic [1:0]  i_ext2_priority_bits,
  input  wire logic [1:0]  i_ext3_priority_bits,
  input  wire logic [1:0]  i_serial_priority_bits,
  input  wire logic [1:0]  i_timer2_priority_bits,
  input  wire logic        i_power_control_register_write,
  input  wire logic [7:0]  i_power_control_register_wdata,
  input  wire logic        i_vector_ack,
  input  wire logic        i_service_return,
  output logic             o_irq_request,
  output logic [15:0]      o_vector_address,
  output logic [3:0]       o_irq_source,
  output logic             o_brownout_reset,
  output logic             o_idle_request_bit,
  output logic             o_powerdown_request_bit,
  output logic             o_cpu_halt,
  output logic             o_clock_stop,
  output logic             o_ale,
  output logic             o_program_store_enable_n
);

  logic [IPM_NUM_SRC-1:0] src_pend;
  logic [IPM_NUM_SRC-1:0] src_en;
  logic [1:0]             src_prio [IPM_NUM_SRC];
  logic [15:0]            src_vec  [IPM_NUM_SRC];
  logic [IPM_NUM_SRC-1:0] src_ok;
  logic [2:0]             active_level;
  logic                   order_ok;
  logic [3:0]             win_idx;
  logic [2:0]             win_level;
  logic                   win_valid;
  logic                   take;
  logic                   wake_pd;
  logic                   ext_pin_low;
  ipm_mode_e              mode;
  ipm_mode_e              next_mode;

  // Shared sources are OR-ed once so each gets one vector and one enable.
  assign src_pend[IPM_SRC_EXT0] = i_ext0_request_flag;
  assign src_pend[IPM_SRC_BO]   = i_brownout;
  assign src_pend[IPM_SRC_T0]   = i_timer0_overflow_flag;
  assign src_pend[IPM_SRC_EXT1] = i_ext1_request_flag;
  assign src_pend[IPM_SRC_T1]   = i_timer1_overflow_flag;
  assign src_pend[IPM_SRC_PCA]  = i_counter_array_overflow_flag | i_counter_module_match_flag;
  assign src_pend[IPM_SRC_EXT2] = i_ext2_request_flag;
  assign src_pend[IPM_SRC_EXT3] = i_ext3_request_flag;
  assign src_pend[IPM_SRC_SER]  = i_serial_transmit_flag | i_serial_receive_flag |
                                  i_spi_done_flag;
  assign src_pend[IPM_SRC_T2]   = i_timer2_overflow_flag | i_timer2_external_flag;

  // Per-source enables in polling order.
  assign src_en = {i_timer2_irq_enable, i_serial_irq_enable, i_ext3_enable, i_ext2_enable,
                   i_counter_array_irq_enable, i_timer1_irq_enable, i_ext1_enable,
                   i_timer0_irq_enable, i_brownout_irq_enable, i_ext0_enable};

  // Priority pairs and vectors in polling order.
  assign src_prio[IPM_SRC_EXT0] = i_ext0_priority_bits;
  assign src_prio[IPM_SRC_BO]   = i_brownout_priority_bits;
  assign src_prio[IPM_SRC_T0]   = i_timer0_priority_bits;
  assign src_prio[IPM_SRC_EXT1] = i_ext1_priority_bits;
  assign src_prio[IPM_SRC_T1]   = i_timer1_priority_bits;
  assign src_prio[IPM_SRC_PCA]  = i_counter_array_priority_bits;
  assign src_prio[IPM_SRC_EXT2] = i_ext2_priority_bits;
  assign src_prio[IPM_SRC_EXT3] = i_ext3_priority_bits;
  assign src_prio[IPM_SRC_SER]  = i_serial_priority_bits;
  assign src_prio[IPM_SRC_T2]   = i_timer2_priority_bits;
  assign src_vec[IPM_SRC_EXT0]  = IPM_VEC_EXT0;
  assign src_vec[IPM_SRC_BO]    = IPM_VEC_BO;
  assign src_vec[IPM_SRC_T0]    = IPM_VEC_T0;
  assign src_vec[IPM_SRC_EXT1]  = IPM_VEC_EXT1;
  assign src_vec[IPM_SRC_T1]    = IPM_VEC_T1;
  assign src_vec[IPM_SRC_PCA]   = IPM_VEC_PCA;
  assign src_vec[IPM_SRC_EXT2]  = IPM_VEC_EXT2;
  assign src_vec[IPM_SRC_EXT3]  = IPM_VEC_EXT3;
  assign src_vec[IPM_SRC_SER]   = IPM_VEC_SER;
  assign src_vec[IPM_SRC_T2]    = IPM_VEC_T2;

  // A source qualifies only when enabled both locally and globally. In power-down
  // the clock is notionally stopped, so only level external 0 and 1 stay eligible.
  genvar g;
  generate
    for (g = 0; g < IPM_NUM_SRC; g++) begin : g_qual
      if (g == IPM_SRC_EXT0 || g == IPM_SRC_EXT1) begin : g_wake
        logic lvl;
        assign lvl = (g == IPM_SRC_EXT0) ? i_ext0_level_mode : i_ext1_level_mode;
        assign src_ok[g] = src_pend[g] & src_en[g] & i_global_enable &
                           ((mode != IPM_PDOWN) | lvl);
      end else begin : g_plain
        assign src_ok[g] = src_pend[g] & src_en[g] & i_global_enable &
                           (mode != IPM_PDOWN);
      end
    end
  endgenerate

  // Highest level wins; scanning from the last source lets earlier ones
  // overwrite on equal level, which gives the fixed polling order.
  always_comb begin
    win_idx   = 4'h0;
    win_level = IPM_LEVEL_NONE;
    win_valid = 1'b0;
    for (int i = IPM_NUM_SRC - 1; i >= 0; i--) begin
      if (src_ok[i] && (!win_valid || {1'b0, src_prio[i]} >= win_level)) begin
        win_idx   = 4'(i);
        win_level = {1'b0, src_prio[i]};
        win_valid = 1'b1;
      end
    end
  end

  // Active level is one above the level number so that level 0 can preempt nothing.
  logic [3:0] in_service;
  always_comb begin
    int k;
    k = 0;
    for (int j = 0; j < 4; j++) begin
      if (in_service[j]) begin
        k = j + 1;
      end
    end
    active_level = 3'(k);
  end

  // A request is offered only while strictly above the running routine.
  assign o_irq_request = win_valid && ((win_level + 3'h1) > active_level);
  assign take          = o_irq_request && i_vector_ack;
  assign ext_pin_low   = src_ok[IPM_SRC_EXT0] | src_ok[IPM_SRC_EXT1];
  assign wake_pd       = (mode == IPM_PDOWN) && take;

  // Vector and source number come from flops so they are stable at the ack.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_vector_address <= IPM_VEC_RESET;
      o_irq_source     <= 4'h0;
    end else if (!take) begin
      o_vector_address <= src_vec[win_idx];
      o_irq_source     <= win_idx;
    end
  end

  // One bit per level marks a routine in progress; a return clears the top one.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      in_service <= 4'h0;
    end else if (take) begin
      in_service[win_level[1:0]] <= 1'b1;
    end else if (i_service_return) begin
      in_service <= in_service & ~(4'h1 << (active_level - 3'h1));
    end
  end

  // Brown-out with its enable clear forces a restart from address zero.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_brownout_reset <= 1'b0;
    end else begin
      o_brownout_reset <= i_brownout && !i_brownout_irq_enable;
    end
  end

  // Power mode: entry by power control writes, exit by a taken interrupt.
  always_comb begin
    next_mode = mode;
    case (mode)
      IPM_RUN: begin
        if (i_power_control_register_write && i_power_control_register_wdata[IPM_POWER_CONTROL_REGISTER_PD_BIT]) begin
          next_mode = IPM_PDOWN;
        end else if (i_power_control_register_write && i_power_control_register_wdata[IPM_POWER_CONTROL_REGISTER_IDL_BIT]) begin
          next_mode = IPM_IDLE;
        end
      end
      IPM_IDLE: begin
        if (take) begin
          next_mode = IPM_RUN;
        end
      end
      IPM_PDOWN: begin
        if (wake_pd) begin
          next_mode = IPM_RUN;
        end
      end
      default: next_mode = IPM_RUN;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      mode <= IPM_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // The core is halted; its registers simply hold because it stops fetching.
  assign o_idle_request_bit      = (mode == IPM_IDLE);
  assign o_powerdown_request_bit = (mode == IPM_PDOWN);
  assign o_cpu_halt              = (mode != IPM_RUN);
  // The clock runs again as soon as a wake pin is pulled low, so the routine
  // can start while the external agent still holds the pin low.
  assign o_clock_stop            = (mode == IPM_PDOWN) && !ext_pin_low;
  assign o_ale                   = (mode != IPM_PDOWN);
  assign o_program_store_enable_n = (mode != IPM_PDOWN);

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_idle_write;
    (mode == IPM_RUN) && i_power_control_register_write && (i_power_control_register_wdata == IPM_POWER_CONTROL_REGISTER_IDLE_VAL);
  endsequence

  sequence s_pd_write;
    (mode == IPM_RUN) && i_power_control_register_write && (i_power_control_register_wdata == IPM_POWER_CONTROL_REGISTER_PD_VAL);
  endsequence

  idle_entry_a: assert property (s_idle_write |=> o_idle_request_bit && o_cpu_halt)
    else $error("idle not entered after idle write");
  pd_entry_a: assert property (s_pd_write |=> o_powerdown_request_bit)
    else $error("power-down not entered");
  idle_exit_a: assert property (o_idle_request_bit && take |=> !o_idle_request_bit)
    else $error("idle bit not cleared on interrupt");
  pd_wake_a: assert property (o_powerdown_request_bit && take |=> !o_powerdown_request_bit)
    else $error("power-down bit not cleared on wake");
  pd_wake_src_a: assert property (o_powerdown_request_bit && o_irq_request |->
    (win_idx == 4'h0 || win_idx == 4'h3))
    else $error("illegal power-down wake source");
  idle_pins_a: assert property (o_idle_request_bit |-> o_ale && o_program_store_enable_n)
    else $error("strobes not high in idle");
  pd_pins_a: assert property (o_powerdown_request_bit |-> !o_ale && !o_program_store_enable_n)
    else $error("strobes not low in power-down");
  preempt_a: assert property (o_irq_request |-> (win_level + 3'h1) > active_level)
    else $error("request offered without higher level");
  enable_a: assert property (o_irq_request |-> i_global_enable)
    else $error("request without global enable");
  brownout_a: assert property (i_brownout && !i_brownout_irq_enable |=> o_brownout_reset)
    else $error("brown-out reset missing");
  vector_a: assert property (o_irq_request && $stable(win_idx) |=>
    o_vector_address == src_vec[o_irq_source])
    else $error("vector does not match source");
  serial_a: assert property (o_irq_request && win_idx == 4'h8 |->
    src_en[IPM_SRC_SER])
    else $error("serial request without its enable");
  reset_a: assert property (@(posedge i_clk_sys) disable iff (1'b0)
    i_rst |=> mode == IPM_RUN && in_service == 4'h0)
    else $error("reset did not clear mode");

  // Order check helper: no qualified source may outrank the winner, and an
  // equal-level winner must be the earliest polled one. It is written apart
  // from the arbiter so that a slip in the scan direction shows up here.
  always_comb begin
    order_ok = 1'b1;
    for (int i = 0; i < IPM_NUM_SRC; i++) begin
      if (src_ok[i] && ({1'b0, src_prio[i]} > win_level)) begin
        order_ok = 1'b0;
      end
      if (src_ok[i] && ({1'b0, src_prio[i]} == win_level) && (4'(i) < win_idx)) begin
        order_ok = 1'b0;
      end
    end
  end

  sequence s_pd_take;
    o_powerdown_request_bit && take;
  endsequence

  sequence s_idle_take;
    o_idle_request_bit && take;
  endsequence

  // Arbitration results.
  poll_order_a: assert property (o_irq_request |-> order_ok)
    else $error("winner outranked by another source");
  src_range_a: assert property (o_irq_request |-> win_idx < 4'ha)
    else $error("winner index out of range");
  vec_hold_a: assert property (take |=> $stable(o_vector_address))
    else $error("vector moved at the ack");
  // Nesting bookkeeping.
  nest_mark_a: assert property (take |=> active_level != IPM_LEVEL_NONE)
    else $error("taken request not marked in service");
  ret_drop_a: assert property (i_service_return && !take && active_level != IPM_LEVEL_NONE
    |=> active_level < $past(active_level))
    else $error("return did not lower the active level");
  // Low-power behaviour.
  pd_quiet_a: assert property (o_powerdown_request_bit && !ext_pin_low |->
    !o_irq_request && o_clock_stop)
    else $error("power-down disturbed without wake pin");
  power_control_register_locked_a: assert property (mode != IPM_RUN && i_power_control_register_write && !take |=>
    mode == $past(mode))
    else $error("power control write accepted outside run");
  idle_wake_a: assert property (s_idle_take |=> !o_cpu_halt)
    else $error("core still halted after idle wake");
  pd_run_a: assert property (s_pd_take |=> !o_cpu_halt && o_ale)
    else $error("core still halted after power-down wake");
  halt_mode_a: assert property (o_cpu_halt |-> o_idle_request_bit || o_powerdown_request_bit)
    else $error("core halted outside low power");
endmodule : ipm_interrupt_power

//--- verilog/ipm_pkg.sv
package ipm_pkg;
  // Source indices in polling order; index 0 is polled first.
  localparam int unsigned IPM_NUM_SRC  = 10;
  localparam int unsigned IPM_SRC_EXT0 = 0;
  localparam int unsigned IPM_SRC_BO   = 1;
  localparam int unsigned IPM_SRC_T0   = 2;
  localparam int unsigned IPM_SRC_EXT1 = 3;
  localparam int unsigned IPM_SRC_T1   = 4;
  localparam int unsigned IPM_SRC_PCA  = 5;
  localparam int unsigned IPM_SRC_EXT2 = 6;
  localparam int unsigned IPM_SRC_EXT3 = 7;
  localparam int unsigned IPM_SRC_SER  = 8;
  localparam int unsigned IPM_SRC_T2   = 9;

  // Vector addresses by source index.
  localparam logic [15:0] IPM_VEC_EXT0  = 16'h0003;
  localparam logic [15:0] IPM_VEC_BO    = 16'h004b;
  localparam logic [15:0] IPM_VEC_T0    = 16'h000b;
  localparam logic [15:0] IPM_VEC_EXT1  = 16'h0013;
  localparam logic [15:0] IPM_VEC_T1    = 16'h001b;
  localparam logic [15:0] IPM_VEC_PCA   = 16'h0033;
  localparam logic [15:0] IPM_VEC_EXT2  = 16'h003b;
  localparam logic [15:0] IPM_VEC_EXT3  = 16'h0043;
  localparam logic [15:0] IPM_VEC_SER   = 16'h0023;
  localparam logic [15:0] IPM_VEC_T2    = 16'h002b;
  localparam logic [15:0] IPM_VEC_RESET = 16'h0000;

  // Power control write values and bit positions.
  localparam logic [7:0] IPM_POWER_CONTROL_REGISTER_IDLE_VAL = 8'h01;
  localparam logic [7:0] IPM_POWER_CONTROL_REGISTER_PD_VAL   = 8'h02;
  localparam int unsigned IPM_POWER_CONTROL_REGISTER_IDL_BIT = 0;
  localparam int unsigned IPM_POWER_CONTROL_REGISTER_PD_BIT  = 1;
  localparam logic [7:0] IPM_POWER_CONTROL_REGISTER_RESET    = 8'h00;

  // Brown-out enable location in the extended enable register.
  localparam logic [7:0] IPM_IEA_ADDR   = 8'he8;
  localparam int unsigned IPM_EBO_BIT   = 3;

  // Level used when no service routine is active.
  localparam logic [2:0] IPM_LEVEL_NONE = 3'h0;

  typedef enum logic [1:0] {
    IPM_RUN   = 2'b00,
    IPM_IDLE  = 2'b01,
    IPM_PDOWN = 2'b11
  } ipm_mode_e;
endpackage : ipm_pkg
